//--- rtl/flash_status_poller.sv
// Host controller that polls flash write status and recovers on timeout
`timescale 1ns/100ps
`include "flash_status_params.svh"

module flash_status_poller #(
  parameter logic [`FLASH_DATA_W-1:0] RESET_CMD = `FLASH_RESET_CMD
) (
  input  wire logic                              ref_clk,
  input  wire logic                              rst_n,
  input  wire logic                              reqValid,
  input  wire flash_status_pkg::user_req_s       req,
  output logic                                   reqReady,
  output logic                                   respValid,
  output logic                                   respFail,
  output logic [`FLASH_DATA_W-1:0]               respData,
  output logic                                   deviceBusy,
  output logic [`FLASH_ADDR_W-1:0]               flashAddr,
  output logic [`FLASH_DATA_W-1:0]               flashDataOut,
  output logic                                   flashDataOe,
  input  wire logic [`FLASH_DATA_W-1:0]          flashDataIn,
  output logic                                   chipSelectN,
  output logic                                   outputStrobeN,
  output logic                                   writeStrobeN,
  input  wire logic                              readyBusyN
);

  localparam flash_status_pkg::top_state_s RST_STATE = '{
    state:     flash_status_pkg::ST_IDLE,
    first:     '0,
    rybySync1: 1'b1,
    rybySync2: 1'b1,
    busy:      1'b0,
    go:        1'b0,
    breq:      '0,
    reqReady:  1'b1,
    respValid: 1'b0,
    respFail:  1'b0,
    respData:  '0
  };

  flash_status_pkg::top_state_s q;
  flash_status_pkg::top_state_s d;
  logic                         busDone;
  logic [`FLASH_DATA_W-1:0]     busRdData;
  logic                         toggled;

  //////////////////////////////////////////////////////////////////////////////

  flash_bus_cycle u_bus (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .go            (q.go),
    .req           (q.breq),
    .done          (busDone),
    .rdData        (busRdData),
    .flashAddr     (flashAddr),
    .flashDataOut  (flashDataOut),
    .flashDataOe   (flashDataOe),
    .flashDataIn   (flashDataIn),
    .chipSelectN   (chipSelectN),
    .outputStrobeN (outputStrobeN),
    .writeStrobeN  (writeStrobeN)
  );

  // Two reads differing in the toggle bit mean the algorithm is still running
  assign toggled = busRdData[`FLASH_BIT_TOGA] != q.first[`FLASH_BIT_TOGA];

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    d           = q;
    d.go        = 1'b0;
    d.respValid = 1'b0;
    d.rybySync1 = readyBusyN;
    d.rybySync2 = q.rybySync1;
    d.busy      = ~q.rybySync2;
    case (q.state)
      flash_status_pkg::ST_IDLE: begin
        if (reqValid && q.reqReady) begin
          d.reqReady   = 1'b0;
          d.go         = 1'b1;
          d.breq.addr  = req.addr;
          d.breq.data  = req.data;
          d.breq.write = (req.op == flash_status_pkg::OP_WRITE);
          d.state      = (req.op == flash_status_pkg::OP_POLL) ? flash_status_pkg::ST_RD1
                                                                : flash_status_pkg::ST_SINGLE;
        end
      end
      flash_status_pkg::ST_RD1, flash_status_pkg::ST_RD3: begin
        if (busDone) begin
          d.first = busRdData;
          d.go    = 1'b1;
          d.state = (q.state == flash_status_pkg::ST_RD1) ? flash_status_pkg::ST_RD2
                                                          : flash_status_pkg::ST_RD4;
        end
      end
      flash_status_pkg::ST_RD2: begin
        if (busDone) begin
          if (!toggled) begin
            d.state     = flash_status_pkg::ST_IDLE;
            d.reqReady  = 1'b1;
            d.respValid = 1'b1;
            d.respFail  = 1'b0;
            d.respData  = busRdData;
          end else if (busRdData[`FLASH_BIT_TMO]) begin
            // Toggle may stop just as the timeout flag rises, so look again
            d.go    = 1'b1;
            d.state = flash_status_pkg::ST_RD3;
          end else begin
            d.go    = 1'b1;
            d.state = flash_status_pkg::ST_RD1;
          end
        end
      end
      flash_status_pkg::ST_RD4: begin
        if (busDone) begin
          if (toggled) begin
            d.go         = 1'b1;
            d.breq.write = 1'b1;
            d.breq.data  = RESET_CMD;
            d.respData   = busRdData;
            d.state      = flash_status_pkg::ST_RESET;
          end else begin
            d.state     = flash_status_pkg::ST_IDLE;
            d.reqReady  = 1'b1;
            d.respValid = 1'b1;
            d.respFail  = 1'b0;
            d.respData  = busRdData;
          end
        end
      end
      flash_status_pkg::ST_RESET: begin
        if (busDone) begin
          d.state     = flash_status_pkg::ST_IDLE;
          d.reqReady  = 1'b1;
          d.respValid = 1'b1;
          d.respFail  = 1'b1;
        end
      end
      flash_status_pkg::ST_SINGLE: begin
        // Raw status byte lets software check the window flag around commands
        if (busDone) begin
          d.state     = flash_status_pkg::ST_IDLE;
          d.reqReady  = 1'b1;
          d.respValid = 1'b1;
          d.respFail  = 1'b0;
          d.respData  = q.breq.write ? q.breq.data : busRdData;
        end
      end
      default: begin
        d = RST_STATE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  assign reqReady   = q.reqReady;
  assign respValid  = q.respValid;
  assign respFail   = q.respFail;
  assign respData   = q.respData;
  assign deviceBusy = q.busy;

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_pollDone;
    q.state == flash_status_pkg::ST_RD2 && busDone;
  endsequence

  a_poll_pass: assert property ((s_pollDone and !toggled)
                                |=> q.respValid && !q.respFail)
    else $error("stable toggle bit not reported as pass");
  a_timeout_reread: assert property ((s_pollDone and (toggled && busRdData[`FLASH_BIT_TMO]))
                                     |=> q.state == flash_status_pkg::ST_RD3 && q.go)
    else $error("timeout did not trigger second double read");
  a_poll_restart: assert property ((s_pollDone and (toggled && !busRdData[`FLASH_BIT_TMO]))
                                   |=> q.state == flash_status_pkg::ST_RD1 && q.go)
    else $error("polling did not restart from first read");
  a_fail_reset: assert property (q.state == flash_status_pkg::ST_RD4 && busDone && toggled
                                 |=> q.go && q.breq.write && q.breq.data == RESET_CMD)
    else $error("failure did not issue reset command");
  a_fail_report: assert property (q.state == flash_status_pkg::ST_RESET && busDone
                                  |=> q.respValid && q.respFail)
    else $error("failure not reported after reset write");
  a_single_read: assert property (q.state == flash_status_pkg::ST_SINGLE && busDone
                                  && !q.breq.write |=> q.respData == $past(busRdData))
    else $error("status byte not returned");
  // Go is seen by the cycle engine on the edge it is sampled, select drops one edge later
  a_separate_reads: assert property ($rose(q.go) |-> chipSelectN ##1 !chipSelectN)
    else $error("bus cycle did not start cleanly");
  a_busy_follow: assert property (!readyBusyN [*4] |-> deviceBusy)
    else $error("busy not seen");

endmodule : flash_status_poller

//--- rtl/flash_status_params.svh
// Timing counts, widths and reset values for the flash status poller
`ifndef FLASH_STATUS_PARAMS_SVH
`define FLASH_STATUS_PARAMS_SVH

`define FLASH_ADDR_W      20
`define FLASH_DATA_W      8
`define FLASH_CNT_W       4

`define FLASH_CLK_NS      40
`define FLASH_T_ACC_NS    100
`define FLASH_T_WP_NS     50
`define FLASH_T_HIGH_NS   30
`define FLASH_SYNC_CYC    2

// Least times round up to whole cycles
`define FLASH_CEIL(ns)    ((((ns) + `FLASH_CLK_NS - 1) / `FLASH_CLK_NS))
`define FLASH_ACC_CYC     (`FLASH_CEIL(`FLASH_T_ACC_NS))
`define FLASH_RD_CYC      (`FLASH_ACC_CYC + `FLASH_SYNC_CYC)
`define FLASH_WP_CYC      (`FLASH_CEIL(`FLASH_T_WP_NS))
`define FLASH_HIGH_CYC    (`FLASH_CEIL(`FLASH_T_HIGH_NS))

`define FLASH_BIT_POLL    7
`define FLASH_BIT_TOGA    6
`define FLASH_BIT_TMO     5
`define FLASH_BIT_WIN     3
`define FLASH_BIT_TOGB    2

`define FLASH_RESET_CMD   8'hf0
`define FLASH_STROBE_RST  1'b1

`endif

//--- rtl/flash_status_pkg.sv
// Types shared by the flash status poller and its bus cycle engine
`include "flash_status_params.svh"

package flash_status_pkg;

  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_WRITE = 2'h1,
    OP_POLL  = 2'h2
  } user_op_e;

  typedef struct packed {
    user_op_e                  op;
    logic [`FLASH_ADDR_W-1:0]  addr;
    logic [`FLASH_DATA_W-1:0]  data;
  } user_req_s;

  typedef struct packed {
    logic                      write;
    logic [`FLASH_ADDR_W-1:0]  addr;
    logic [`FLASH_DATA_W-1:0]  data;
  } bus_req_s;

  typedef enum logic [1:0] {
    PH_IDLE    = 2'h0,
    PH_ACTIVE  = 2'h1,
    PH_RECOVER = 2'h2
  } bus_phase_e;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_RD1    = 3'h1,
    ST_RD2    = 3'h2,
    ST_RD3    = 3'h3,
    ST_RD4    = 3'h4,
    ST_RESET  = 3'h5,
    ST_SINGLE = 3'h6
  } poll_state_e;

  typedef struct packed {
    bus_phase_e                phase;
    logic [`FLASH_CNT_W-1:0]   cnt;
    logic                      ceN;
    logic                      oeN;
    logic                      weN;
    logic [`FLASH_ADDR_W-1:0]  addr;
    logic [`FLASH_DATA_W-1:0]  dOut;
    logic                      dOe;
    logic [`FLASH_DATA_W-1:0]  dSync1;
    logic [`FLASH_DATA_W-1:0]  dSync2;
    logic [`FLASH_DATA_W-1:0]  rdData;
    logic                      done;
  } bus_state_s;

  typedef struct packed {
    poll_state_e               state;
    logic [`FLASH_DATA_W-1:0]  first;
    logic                      rybySync1;
    logic                      rybySync2;
    logic                      busy;
    logic                      go;
    bus_req_s                  breq;
    logic                      reqReady;
    logic                      respValid;
    logic                      respFail;
    logic [`FLASH_DATA_W-1:0]  respData;
  } top_state_s;

endpackage : flash_status_pkg

//--- rtl/flash_bus_cycle.sv
// One asynchronous read or write cycle on the flash strobes
`timescale 1ns/100ps
`include "flash_status_params.svh"

module flash_bus_cycle (
  input  wire logic                              ref_clk,
  input  wire logic                              rst_n,
  input  wire logic                              go,
  input  wire flash_status_pkg::bus_req_s        req,
  output logic                                   done,
  output logic [`FLASH_DATA_W-1:0]               rdData,
  output logic [`FLASH_ADDR_W-1:0]               flashAddr,
  output logic [`FLASH_DATA_W-1:0]               flashDataOut,
  output logic                                   flashDataOe,
  input  wire logic [`FLASH_DATA_W-1:0]          flashDataIn,
  output logic                                   chipSelectN,
  output logic                                   outputStrobeN,
  output logic                                   writeStrobeN
);

  localparam flash_status_pkg::bus_state_s RST_STATE = '{
    phase:  flash_status_pkg::PH_IDLE,
    cnt:    '0,
    ceN:    `FLASH_STROBE_RST,
    oeN:    `FLASH_STROBE_RST,
    weN:    `FLASH_STROBE_RST,
    addr:   '0,
    dOut:   '0,
    dOe:    1'b0,
    dSync1: '0,
    dSync2: '0,
    rdData: '0,
    done:   1'b0
  };

  flash_status_pkg::bus_state_s q;
  flash_status_pkg::bus_state_s d;

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    d        = q;
    d.done   = 1'b0;
    d.dSync1 = flashDataIn;
    d.dSync2 = q.dSync1;
    case (q.phase)
      flash_status_pkg::PH_IDLE: begin
        if (go) begin
          d.phase = flash_status_pkg::PH_ACTIVE;
          d.addr  = req.addr;
          d.dOut  = req.data;
          d.dOe   = req.write;
          d.ceN   = 1'b0;
          d.oeN   = req.write;
          d.weN   = ~req.write;
          // Reads include synchroniser latency so the sample lands after access
          d.cnt   = req.write ? `FLASH_CNT_W'(`FLASH_WP_CYC - 1)
                              : `FLASH_CNT_W'(`FLASH_RD_CYC - 1);
        end
      end
      flash_status_pkg::PH_ACTIVE: begin
        if (q.cnt == '0) begin
          d.phase  = flash_status_pkg::PH_RECOVER;
          d.cnt    = `FLASH_CNT_W'(`FLASH_HIGH_CYC - 1);
          d.ceN    = 1'b1;
          d.oeN    = 1'b1;
          d.weN    = 1'b1;
          d.dOe    = 1'b0;
          d.rdData = q.dSync2;
        end else begin
          d.cnt = q.cnt - `FLASH_CNT_W'(1);
        end
      end
      flash_status_pkg::PH_RECOVER: begin
        // Strobes stay high so the next read is a new cycle
        if (q.cnt == '0) begin
          d.phase = flash_status_pkg::PH_IDLE;
          d.done  = 1'b1;
        end else begin
          d.cnt = q.cnt - `FLASH_CNT_W'(1);
        end
      end
      default: begin
        d = RST_STATE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  assign done          = q.done;
  assign rdData        = q.rdData;
  assign flashAddr     = q.addr;
  assign flashDataOut  = q.dOut;
  assign flashDataOe   = q.dOe;
  assign chipSelectN   = q.ceN;
  assign outputStrobeN = q.oeN;
  assign writeStrobeN  = q.weN;

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_readLow;
    (!q.oeN && !q.ceN) [*5];
  endsequence

  sequence s_strobesHigh;
    q.ceN && q.oeN && q.weN;
  endsequence

  a_read_cycle_len: assert property ($fell(q.oeN) |-> s_readLow ##1 s_strobesHigh)
    else $error("read strobe length wrong");
  a_read_separate: assert property ($rose(q.ceN) |-> s_strobesHigh ##1 q.done)
    else $error("read cycles not separated");
  a_write_pulse: assert property ($fell(q.weN) |-> (!q.weN && q.dOe) [*2]
                                 ##1 s_strobesHigh)
    else $error("write pulse length wrong");

endmodule : flash_bus_cycle

//--- tb/flash_status_model.sv
// Behavioural flash that reports write status on its data pins
`timescale 1ns/100ps

module flash_status_model (
  input  wire logic        chipSelectN,
  input  wire logic        outputStrobeN,
  input  wire logic        writeStrobeN,
  input  wire logic [19:0] addr,
  input  wire logic [7:0]  hostData,
  input  wire logic        hostOe,
  input  wire logic        load,
  input  wire logic [1:0]  loadKind,
  input  wire logic [7:0]  loadReads,
  input  wire logic [7:0]  arrayByte,
  input  wire logic        suspend,
  output logic [7:0]       dataBus,
  output logic             rybyOe,
  output logic [7:0]       lastWrite,
  output logic [19:0]      lastWriteAddr
);
  // Kinds: 0 array read, 1 program, 2 erase, 3 program past its pulse limit
  logic [1:0] kind = 2'h0;
  logic [7:0] left = 8'h00;
  logic       tog6 = 1'b0;
  logic       tog2 = 1'b0;
  logic [7:0] lastDrv = 8'h00;
  logic [7:0] stat;
  logic       inSector;
  logic       toggling;

  initial begin
    lastWrite     = 8'h00;
    lastWriteAddr = 20'h00000;
  end

  // Upper half stands for the unprotected sector picked for erase; lower half is left intact
  assign inSector = addr[19];
  assign toggling = (kind != 2'h0) && !(kind == 2'h2 && suspend);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    stat = arrayByte;
    case (kind)
      2'h1, 2'h3: stat = {~arrayByte[7], tog6, kind == 2'h3, arrayByte[4:0]};
      2'h2: begin
        if (!suspend)
          stat = {1'b0, tog6, 1'b0, arrayByte[4], 1'b1, inSector ? tog2 : arrayByte[2],
                  arrayByte[1:0]};
        else if (inSector)
          stat = {1'b1, tog6, 1'b0, arrayByte[4:3], tog2, arrayByte[1:0]};
      end
      default: stat = arrayByte;
    endcase
  end

  // Undriven pins show the inverse of the last byte, never a stale copy
  assign dataBus = hostOe ? hostData : (!chipSelectN && !outputStrobeN) ? stat : ~lastDrv;
  assign rybyOe  = (kind == 2'h1) || (kind == 2'h3) || (kind == 2'h2 && !suspend);

  ////////////////////////////////////////////////////////////////////////
  always @(posedge load) begin
    kind = loadKind;
    left = loadReads;
  end

  // A read ends when either strobe rises, so both pacing styles work
  always @(posedge (chipSelectN | outputStrobeN)) begin
    lastDrv = stat;
    if (kind == 2'h2 && inSector)
      tog2 = ~tog2;
    if (toggling) begin
      tog6 = ~tog6;
      if (left <= 8'h01)
        kind = 2'h0;
      else
        left = left - 8'h01;
    end
  end

  // Sample 20 ns into the pulse: host data may drop on the same edge the strobe rises
  always @(negedge writeStrobeN) begin
    #20;
    if (!chipSelectN) begin
      lastWrite     = hostData;
      lastWriteAddr = addr;
      if (hostData == 8'hf0)
        kind = 2'h0;
    end
  end
endmodule : flash_status_model

//--- tb/testbench.sv
// Self-checking bench for the flash status poller against a flash model
`timescale 1ns/100ps

`define CHK(act, exp) begin checksDone++; if ((act) !== (exp)) begin failCount++; \
  $display("unexpected at %0t: got %h expected %h", $time, (act), (exp)); end end

module testbench;
  logic                          ref_clk, rst_n, reqValid, reqReady, respValid, respFail;
  logic                          deviceBusy, flashDataOe, chipSelectN, outputStrobeN;
  logic                          writeStrobeN, readyBusyN, rybyOe, load, suspend;
  flash_status_pkg::user_req_s   req;
  logic [7:0]                    respData, flashDataOut, dataBus, lastWrite, arrayByte;
  logic [7:0]                    loadReads, r1;
  logic [19:0]                   flashAddr, lastWriteAddr;
  logic [1:0]                    loadKind;
  int                            failCount = 0, checksDone = 0, cycles = 0, cyc;

  assign readyBusyN = rybyOe ? 1'b0 : 1'b1; // Pull-up on the open-drain line

  flash_status_poller u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .respValid(respValid), .respFail(respFail), .respData(respData),
    .deviceBusy(deviceBusy), .flashAddr(flashAddr), .flashDataOut(flashDataOut),
    .flashDataOe(flashDataOe), .flashDataIn(dataBus), .chipSelectN(chipSelectN),
    .outputStrobeN(outputStrobeN), .writeStrobeN(writeStrobeN), .readyBusyN(readyBusyN));

  flash_status_model u_flash (.chipSelectN(chipSelectN), .outputStrobeN(outputStrobeN),
    .writeStrobeN(writeStrobeN), .addr(flashAddr), .hostData(flashDataOut),
    .hostOe(flashDataOe), .load(load), .loadKind(loadKind), .loadReads(loadReads),
    .arrayByte(arrayByte), .suspend(suspend), .dataBus(dataBus), .rybyOe(rybyOe),
    .lastWrite(lastWrite), .lastWriteAddr(lastWriteAddr));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic giveVerdict;
    $display("counts: %0d checks, %0d mismatches", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : giveVerdict

  // Whole run needs a few hundred cycles; a hang stops here
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failCount++;
      giveVerdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic doReq(input flash_status_pkg::user_op_e op, input logic [19:0] a,
                       input logic [7:0] d);
    @(posedge ref_clk);
    reqValid <= 1'b1;
    req      <= '{op, a, d};
    do @(posedge ref_clk); while (reqReady !== 1'b1);
    reqValid <= 1'b0;
    cyc = 0;
    do begin
      @(posedge ref_clk);
      #1;
      cyc++;
    end while (respValid !== 1'b1 && cyc < 5000);
  endtask : doReq

  task automatic setDev(input logic [1:0] k, input logic [7:0] n);
    @(posedge ref_clk);
    loadKind  <= k;
    loadReads <= n;
    load      <= 1'b1;
    @(posedge ref_clk);
    load      <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : setDev

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0; reqValid = 1'b0; req = '0; load = 1'b0; loadKind = 2'h0;
    loadReads = 8'h00; arrayByte = 8'h4b; suspend = 1'b0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    doReq(flash_status_pkg::OP_WRITE, 20'h00555, 8'haa);
    `CHK(cyc, 5)
    `CHK(lastWrite, 8'haa)
    `CHK(respData, 8'haa)
    doReq(flash_status_pkg::OP_READ, 20'h00100, 8'h00);
    `CHK(cyc, 8)
    `CHK(respData, 8'h4b)
    doReq(flash_status_pkg::OP_POLL, 20'h00100, 8'h00);
    `CHK(cyc, 16)
    `CHK(respFail, 1'b0)
    `CHK(respData, 8'h4b)
    $display("test single cycles done, mismatches %0d", failCount);
    setDev(2'h1, 8'h06);
    `CHK(deviceBusy, 1'b1)
    doReq(flash_status_pkg::OP_READ, 20'h00100, 8'h00);
    `CHK(respData[7], 1'b1)
    doReq(flash_status_pkg::OP_POLL, 20'h00100, 8'h00);
    `CHK(respFail, 1'b0)
    `CHK(respData, 8'h4b)
    `CHK(cyc > 16, 1'b1)
    repeat (4) @(posedge ref_clk);
    #1;
    `CHK(deviceBusy, 1'b0)
    $display("test program poll done, mismatches %0d", failCount);
    setDev(2'h3, 8'hc8);
    doReq(flash_status_pkg::OP_POLL, 20'h01234, 8'h00);
    `CHK(respFail, 1'b1)
    `CHK(lastWrite, 8'hf0)
    `CHK(lastWriteAddr, 20'h01234)
    setDev(2'h3, 8'h02);
    doReq(flash_status_pkg::OP_POLL, 20'h01234, 8'h00);
    `CHK(respFail, 1'b0)
    `CHK(respData, 8'h4b)
    $display("test timeout poll done, mismatches %0d", failCount);
    suspend <= 1'b1;
    setDev(2'h2, 8'h0a);
    `CHK(deviceBusy, 1'b0)
    doReq(flash_status_pkg::OP_READ, 20'h80000, 8'h00);
    r1 = respData;
    doReq(flash_status_pkg::OP_READ, 20'h80000, 8'h00);
    `CHK(respData[7], 1'b1)
    `CHK(respData[6], r1[6])
    `CHK(respData[5], 1'b0)
    `CHK(respData[2], ~r1[2])
    doReq(flash_status_pkg::OP_READ, 20'h00100, 8'h00);
    `CHK(respData, 8'h4b)
    doReq(flash_status_pkg::OP_POLL, 20'h80000, 8'h00);
    `CHK(respFail, 1'b0)
    suspend <= 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    `CHK(deviceBusy, 1'b1)
    doReq(flash_status_pkg::OP_POLL, 20'h80000, 8'h00);
    `CHK(respFail, 1'b0)
    `CHK(respData, 8'h4b)
    `CHK(cyc > 16, 1'b1)
    $display("test erase suspend done, mismatches %0d", failCount);
    giveVerdict();
  end
endmodule : testbench
